// file: hdl/cputmr_consts.svh
// cpu timer constants: register indices, field positions, reset values
`ifndef CPUTMR_CONSTS_SVH
`define CPUTMR_CONSTS_SVH

// register indices; byte address is index times four
`define CPUTMR_IDX_CNT_LO    3'h0
`define CPUTMR_IDX_CNT_HI    3'h1
`define CPUTMR_IDX_PRD_LO    3'h2
`define CPUTMR_IDX_PRD_HI    3'h3
`define CPUTMR_IDX_CTRL      3'h4
`define CPUTMR_IDX_RSVD      3'h5
`define CPUTMR_IDX_DIV_LO    3'h6
`define CPUTMR_IDX_DIV_HI    3'h7

// control register fields
`define CPUTMR_BIT_FLAG      15
`define CPUTMR_BIT_IRQ_EN    14
`define CPUTMR_BIT_FREE      11
`define CPUTMR_BIT_SOFT      10
`define CPUTMR_BIT_RELOAD    5
`define CPUTMR_BIT_STOP      4

// reset values
`define CPUTMR_RST_PERIOD    32'h0000ffff
`define CPUTMR_RST_COUNT     32'h00000000
`define CPUTMR_RST_DIVIDE    32'h00000000

// bus responses
`define CPUTMR_RESP_OKAY     2'h0
`define CPUTMR_RESP_SLVERR   2'h2

`endif

// file: hdl/cputmr_pkg.sv
// cpu timer types
package cputmr_pkg;

    typedef enum logic [0:0] {
        EMU_RUN  = 1'b0,
        EMU_STOP = 1'b1
    } cputmr_emu_e;

    typedef struct packed {
        logic flag;
        logic irq_en;
        logic free_run;
        logic soft_stop;
        logic stop;
    } cputmr_ctrl_s;

endpackage

// file: hdl/cputmr_top.sv
// cpu timer with axi4-lite register slave
//
// Implementation choices: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/10ps
`default_nettype none
`include "cputmr_consts.svh"

module cputmr_top
    import cputmr_pkg::*;
#(
    parameter int AW = 8
) (
    input  wire logic          aclk,
    input  wire logic          aresetn,
    input  wire logic [AW-1:0] s_axi_awaddr,
    input  wire logic          s_axi_awvalid,
    output var  logic          s_axi_awready,
    input  wire logic [31:0]   s_axi_wdata,
    input  wire logic [3:0]    s_axi_wstrb,
    input  wire logic          s_axi_wvalid,
    output var  logic          s_axi_wready,
    output var  logic [1:0]    s_axi_bresp,
    output var  logic          s_axi_bvalid,
    input  wire logic          s_axi_bready,
    input  wire logic [AW-1:0] s_axi_araddr,
    input  wire logic          s_axi_arvalid,
    output var  logic          s_axi_arready,
    output var  logic [31:0]   s_axi_rdata,
    output var  logic [1:0]    s_axi_rresp,
    output var  logic          s_axi_rvalid,
    input  wire logic          s_axi_rready,
    input  wire logic          debug_halt,
    output var  logic          timer_irq_out
);

    // =====================================================================
    // bus slave state
    logic [AW-1:0] aw_addr;
    logic [AW-1:0] next_aw_addr;
    logic          aw_full;
    logic          next_aw_full;
    logic [15:0]   w_data;
    logic [15:0]   next_w_data;
    logic [1:0]    w_strb;
    logic [1:0]    next_w_strb;
    logic          w_full;
    logic          next_w_full;
    logic          next_awready;
    logic          next_wready;
    logic          next_arready;
    logic          next_bvalid;
    logic [1:0]    next_bresp;
    logic          next_rvalid;
    logic [1:0]    next_rresp;
    logic [31:0]   next_rdata;
    logic          wr_fire;
    logic          wr_ok;
    logic [2:0]    wr_idx;
    logic [2:0]    rd_idx;
    logic          rd_ok;
    logic [15:0]   rd_word;

    // =====================================================================
    // timer state
    logic [31:0]   count;
    logic [31:0]   next_count;
    logic [31:0]   period;
    logic [31:0]   next_period;
    logic [31:0]   divide;
    logic [31:0]   next_divide;
    logic [31:0]   prescale;
    logic [31:0]   next_prescale;
    cputmr_ctrl_s  ctrl;
    cputmr_ctrl_s  next_ctrl;
    cputmr_emu_e   emu;
    cputmr_emu_e   next_emu;
    logic          next_irq;
    logic          running;
    logic          tick;
    logic          zero_evt;
    logic          reload_wr;
    logic [15:0]   ctrl_rd;

    function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] wd,
                                          input logic [1:0] strb);
        merge = {strb[1] ? wd[15:8] : old[15:8], strb[0] ? wd[7:0] : old[7:0]};
    endfunction

    // =====================================================================
    // address decode
    assign wr_fire = aw_full && w_full && !s_axi_bvalid;
    assign wr_idx  = aw_addr[4:2];
    assign wr_ok   = (aw_addr[AW-1:5] == '0) && (wr_idx != `CPUTMR_IDX_RSVD);
    assign rd_idx  = s_axi_araddr[4:2];
    assign rd_ok   = (s_axi_araddr[AW-1:5] == '0) && (rd_idx != `CPUTMR_IDX_RSVD);

    // reserved bits and the reload trigger always read zero
    assign ctrl_rd = {ctrl.flag, ctrl.irq_en, 2'h0, ctrl.free_run, ctrl.soft_stop,
                      5'h00, ctrl.stop, 4'h0};

    always_comb begin
        case (rd_idx)
            `CPUTMR_IDX_CNT_LO: rd_word = count[15:0];
            `CPUTMR_IDX_CNT_HI: rd_word = count[31:16];
            `CPUTMR_IDX_PRD_LO: rd_word = period[15:0];
            `CPUTMR_IDX_PRD_HI: rd_word = period[31:16];
            `CPUTMR_IDX_CTRL:   rd_word = ctrl_rd;
            `CPUTMR_IDX_DIV_LO: rd_word = divide[15:0];
            `CPUTMR_IDX_DIV_HI: rd_word = divide[31:16];
            default:            rd_word = 16'h0000;
        endcase
    end

    // =====================================================================
    // axi4-lite handshakes; one write and one read in flight
    always_comb begin
        next_aw_addr = aw_addr;
        next_aw_full = aw_full;
        next_w_data  = w_data;
        next_w_strb  = w_strb;
        next_w_full  = w_full;
        next_bvalid  = s_axi_bvalid;
        next_bresp   = s_axi_bresp;
        next_rvalid  = s_axi_rvalid;
        next_rresp   = s_axi_rresp;
        next_rdata   = s_axi_rdata;
        if (s_axi_awvalid && s_axi_awready) begin
            next_aw_addr = s_axi_awaddr;
            next_aw_full = 1'b1;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            next_w_data = s_axi_wdata[15:0];
            next_w_strb = s_axi_wstrb[1:0];
            next_w_full = 1'b1;
        end
        if (wr_fire) begin
            next_aw_full = 1'b0;
            next_w_full  = 1'b0;
            next_bvalid  = 1'b1;
            next_bresp   = wr_ok ? `CPUTMR_RESP_OKAY : `CPUTMR_RESP_SLVERR;
        end else if (s_axi_bvalid && s_axi_bready) begin
            next_bvalid = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            next_rvalid = 1'b1;
            next_rdata  = rd_ok ? {16'h0000, rd_word} : 32'h00000000;
            next_rresp  = rd_ok ? `CPUTMR_RESP_OKAY : `CPUTMR_RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            next_rvalid = 1'b0;
        end
        // ready drops on its handshake and returns once the response is taken
        next_awready = !next_aw_full && !next_bvalid && !(s_axi_awvalid && s_axi_awready);
        next_wready  = !next_w_full && !next_bvalid && !(s_axi_wvalid && s_axi_wready);
        next_arready = !next_rvalid && !(s_axi_arvalid && s_axi_arready);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_addr       <= '0;
            aw_full       <= 1'b0;
            w_data        <= 16'h0000;
            w_strb        <= 2'h0;
            w_full        <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_arready <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `CPUTMR_RESP_OKAY;
            s_axi_rvalid  <= 1'b0;
            s_axi_rresp   <= `CPUTMR_RESP_OKAY;
            s_axi_rdata   <= 32'h00000000;
        end else begin
            aw_addr       <= next_aw_addr;
            aw_full       <= next_aw_full;
            w_data        <= next_w_data;
            w_strb        <= next_w_strb;
            w_full        <= next_w_full;
            s_axi_awready <= next_awready;
            s_axi_wready  <= next_wready;
            s_axi_arready <= next_arready;
            s_axi_bvalid  <= next_bvalid;
            s_axi_bresp   <= next_bresp;
            s_axi_rvalid  <= next_rvalid;
            s_axi_rresp   <= next_rresp;
            s_axi_rdata   <= next_rdata;
        end
    end

    // =====================================================================
    // timer core
    assign reload_wr = wr_fire && wr_ok && (wr_idx == `CPUTMR_IDX_CTRL) && w_strb[0]
                       && w_data[`CPUTMR_BIT_RELOAD];
    // free run overrides a pending emulation halt
    assign running   = !ctrl.stop && !(emu == EMU_STOP && !ctrl.free_run);
    assign tick      = running && !reload_wr && (prescale == 32'h00000000);
    assign zero_evt  = tick && (count == 32'h00000001);

    always_comb begin
        next_count    = count;
        next_period   = period;
        next_divide   = divide;
        next_prescale = prescale;
        next_ctrl     = ctrl;
        next_emu      = emu;
        next_irq      = 1'b0;
        if (running && !reload_wr) begin
            next_prescale = (prescale == 32'h00000000) ? divide : prescale - 32'h00000001;
        end
        if (tick) begin
            next_count = (count == 32'h00000000) ? period : count - 32'h00000001;
        end
        if (wr_fire && wr_ok) begin
            case (wr_idx)
                `CPUTMR_IDX_CNT_LO: next_count[15:0]   = merge(count[15:0], w_data, w_strb);
                `CPUTMR_IDX_CNT_HI: next_count[31:16]  = merge(count[31:16], w_data, w_strb);
                `CPUTMR_IDX_PRD_LO: next_period[15:0]  = merge(period[15:0], w_data, w_strb);
                `CPUTMR_IDX_PRD_HI: next_period[31:16] = merge(period[31:16], w_data, w_strb);
                `CPUTMR_IDX_DIV_LO: next_divide[15:0]  = merge(divide[15:0], w_data, w_strb);
                `CPUTMR_IDX_DIV_HI: next_divide[31:16] = merge(divide[31:16], w_data, w_strb);
                `CPUTMR_IDX_CTRL: begin
                    if (w_strb[1]) begin
                        if (w_data[`CPUTMR_BIT_FLAG]) begin
                            next_ctrl.flag = 1'b0;
                        end
                        next_ctrl.irq_en    = w_data[`CPUTMR_BIT_IRQ_EN];
                        next_ctrl.free_run  = w_data[`CPUTMR_BIT_FREE];
                        next_ctrl.soft_stop = w_data[`CPUTMR_BIT_SOFT];
                    end
                    if (w_strb[0]) begin
                        next_ctrl.stop = w_data[`CPUTMR_BIT_STOP];
                    end
                end
                default: next_ctrl = ctrl;
            endcase
        end
        if (reload_wr) begin
            next_count    = period;
            next_prescale = divide;
        end
        // set beats a same-cycle clear, and ignores the enable
        if (zero_evt) begin
            next_ctrl.flag = 1'b1;
            next_irq       = ctrl.irq_en;
        end
        // emulation halt applies only while the core is held at a breakpoint
        if (!debug_halt) begin
            next_emu = EMU_RUN;
        end else if (emu == EMU_RUN && !ctrl.free_run) begin
            if (!ctrl.soft_stop && tick) begin
                next_emu = EMU_STOP;
            end else if (ctrl.soft_stop && zero_evt) begin
                next_emu = EMU_STOP;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            count         <= `CPUTMR_RST_COUNT;
            period        <= `CPUTMR_RST_PERIOD;
            divide        <= `CPUTMR_RST_DIVIDE;
            prescale      <= `CPUTMR_RST_DIVIDE;
            ctrl          <= '0;
            emu           <= EMU_RUN;
            timer_irq_out <= 1'b0;
        end else begin
            count         <= next_count;
            period        <= next_period;
            divide        <= next_divide;
            prescale      <= next_prescale;
            ctrl          <= next_ctrl;
            emu           <= next_emu;
            timer_irq_out <= next_irq;
        end
    end

    // =====================================================================
    // checks
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence zero_hit_s;
        zero_evt && !reload_wr;
    endsequence

    sequence flag_keep_s;
        ctrl.flag && wr_fire && wr_idx == `CPUTMR_IDX_CTRL && !w_data[`CPUTMR_BIT_FLAG];
    endsequence

    flag_set_a: assert property (zero_hit_s |=> ctrl.flag)
        else $error("flag not set on zero");
    flag_w1c_a: assert property (flag_keep_s |=> ctrl.flag)
        else $error("flag lost on write of zero");
    irq_on_zero_a: assert property (zero_evt && ctrl.irq_en |=> timer_irq_out)
        else $error("no irq on zero");
    irq_masked_a: assert property (!ctrl.irq_en |=> !timer_irq_out)
        else $error("irq while disabled");
    free_run_a: assert property (ctrl.free_run && !ctrl.stop |-> running)
        else $error("free run halted");
    hard_stop_a: assert property (debug_halt && !ctrl.free_run && !ctrl.soft_stop && tick
                                  ##1 debug_halt && !ctrl.free_run |-> !running)
        else $error("hard stop missed");
    soft_stop_a: assert property (debug_halt && !ctrl.free_run && ctrl.soft_stop && tick
                                  && !zero_evt && emu == EMU_RUN |=> emu == EMU_RUN)
        else $error("soft stop halted early");
    reload_a: assert property (reload_wr |=> count == $past(period))
        else $error("reload did not load period");
    wrap_a: assert property (tick && count == 32'h00000000 && !wr_fire
                             |=> count == $past(period))
        else $error("no reload at zero");
    stop_hold_a: assert property (ctrl.stop && !wr_fire |=> $stable(count))
        else $error("count moved while stopped");

    sequence soft_zero_s;
        debug_halt && !ctrl.free_run && ctrl.soft_stop && zero_evt && emu == EMU_RUN;
    endsequence

    sequence late_halt_s;
        !debug_halt ##1 !debug_halt && !ctrl.stop;
    endsequence

    soft_halt_a: assert property (soft_zero_s |=> emu == EMU_STOP)
        else $error("soft stop did not halt at zero");
    soft_irq_a: assert property (soft_zero_s ##0 ctrl.irq_en |=> timer_irq_out)
        else $error("no irq before soft halt");
    run_free_a: assert property (late_halt_s |-> running)
        else $error("timer held outside debug halt");
    flag_clear_a: assert property (wr_fire && wr_ok && wr_idx == `CPUTMR_IDX_CTRL
                                   && w_strb[1] && w_data[`CPUTMR_BIT_FLAG] && !zero_evt
                                   |=> !ctrl.flag)
        else $error("flag not cleared by write of one");
    period_upper_write_a: assert property (wr_fire && wr_ok && wr_idx == `CPUTMR_IDX_PRD_HI
                                   && w_strb == 2'h3 |=> period[31:16] == $past(w_data))
        else $error("period upper half not written");
    ctrl_rsvd_a: assert property (s_axi_arvalid && s_axi_arready && rd_ok
                                  && rd_idx == `CPUTMR_IDX_CTRL
                                  |=> s_axi_rdata[13:12] == 2'h0 && s_axi_rdata[9:5] == 5'h00
                                  && s_axi_rdata[3:0] == 4'h0)
        else $error("reserved or reload bit read nonzero");

    // =====================================================================
    // bus protocol checks; a refused access must never leak register contents
    rd_err_a: assert property (s_axi_arvalid && s_axi_arready && !rd_ok
                               |=> s_axi_rresp == `CPUTMR_RESP_SLVERR
                               && s_axi_rdata == 32'h00000000)
        else $error("unmapped read not refused");
    wr_err_a: assert property (wr_fire && !wr_ok
                               |=> s_axi_bvalid && s_axi_bresp == `CPUTMR_RESP_SLVERR)
        else $error("unmapped write not refused");
    b_hold_a: assert property (s_axi_bvalid && !s_axi_bready
                               |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped early");
    r_hold_a: assert property (s_axi_rvalid && !s_axi_rready
                               |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read response dropped early");

endmodule
`default_nettype wire

// file: testbench/cputmr_host_model.sv
// axi4-lite host model standing in for the processor core
`timescale 1ns/10ps
`default_nettype none
module cputmr_host_model (
    input  wire logic        aclk,
    output var  logic [7:0]  s_axi_awaddr,
    output var  logic        s_axi_awvalid,
    input  wire logic        s_axi_awready,
    output var  logic [31:0] s_axi_wdata,
    output var  logic [3:0]  s_axi_wstrb,
    output var  logic        s_axi_wvalid,
    input  wire logic        s_axi_wready,
    input  wire logic [1:0]  s_axi_bresp,
    input  wire logic        s_axi_bvalid,
    output var  logic        s_axi_bready,
    output var  logic [7:0]  s_axi_araddr,
    output var  logic        s_axi_arvalid,
    input  wire logic        s_axi_arready,
    input  wire logic [31:0] s_axi_rdata,
    input  wire logic [1:0]  s_axi_rresp,
    input  wire logic        s_axi_rvalid,
    output var  logic        s_axi_rready
);
    // ========
    // released addresses and write data carry an inverted copy so stale data never looks valid; the write strobe stays 4'hf
    initial begin
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
        {s_axi_awaddr, s_axi_araddr, s_axi_wstrb} = 20'hfffff;
        s_axi_wdata = 32'h0;
    end
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] resp);
        @(posedge aclk);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_wstrb   <= 4'hf;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        forever begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready === 1'b1) begin
                s_axi_awvalid <= 1'b0;
                s_axi_awaddr  <= ~a;
            end
            if (s_axi_wvalid && s_axi_wready === 1'b1) begin
                s_axi_wvalid <= 1'b0;
                s_axi_wdata  <= ~d;
            end
            if (s_axi_bvalid === 1'b1) begin
                resp = s_axi_bresp;
                s_axi_bready <= 1'b0;
                break;
            end
        end
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
        @(posedge aclk);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        forever begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready === 1'b1) begin
                s_axi_arvalid <= 1'b0;
                s_axi_araddr  <= ~a;
            end
            if (s_axi_rvalid === 1'b1) begin
                d = s_axi_rdata;
                resp = s_axi_rresp;
                s_axi_rready <= 1'b0;
                break;
            end
        end
    endtask
endmodule
`default_nettype wire

// file: testbench/tb_cpu_timer_control_and_period_high.sv
// self-checking bench for the cpu timer control and period logic
`timescale 1ns/10ps
`default_nettype none
`include "cputmr_consts.svh"
module tb_cpu_timer_control_and_period_high;
    localparam logic [7:0] a_cntl = {3'h0, `CPUTMR_IDX_CNT_LO, 2'h0};
    localparam logic [7:0] a_prdl = {3'h0, `CPUTMR_IDX_PRD_LO, 2'h0};
    localparam logic [7:0] a_period_upper = {3'h0, `CPUTMR_IDX_PRD_HI, 2'h0};
    localparam logic [7:0] a_ctrl = {3'h0, `CPUTMR_IDX_CTRL, 2'h0};
    localparam logic [7:0] a_rsvd = {3'h0, `CPUTMR_IDX_RSVD, 2'h0};
    localparam logic [7:0] a_divl = {3'h0, `CPUTMR_IDX_DIV_LO, 2'h0};
    logic        aclk = 1'b0;
    logic        aresetn = 1'b0;
    logic        debug_halt = 1'b0;
    logic        timer_irq_out, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
    logic        s_axi_rready;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    int          mismatches = 0, checked = 0, irq_cnt = 0, cyc = 0, last_irq = 0, irq_gap = 0;
    always #12.5 aclk = ~aclk;
    cputmr_top #(.AW(8)) dut (
        .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .debug_halt, .timer_irq_out
    );
    cputmr_host_model host (
        .aclk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready
    );
    // ========
    // irq pulse monitor: count and spacing in clock cycles
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (timer_irq_out === 1'b1) begin
            irq_cnt  <= irq_cnt + 1;
            irq_gap  <= cyc - last_irq;
            last_irq <= cyc;
        end
    end
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic w(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = 2'h0);
        logic [1:0] r;
        host.wr(a, d, r);
        chk("write response", {30'h0, er}, {30'h0, r});
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er = 2'h0);
        logic [31:0] d;
        logic [1:0]  r;
        host.rd(a, d, r);
        chk("read response", {30'h0, er}, {30'h0, r});
        chk("read data", exp, d);
    endtask
    // two count samples eleven cycles apart; equal means the timer holds
    task automatic moving(input logic exp);
        logic [31:0] d0, d1;
        logic [1:0]  r;
        host.rd(a_cntl, d0, r);
        repeat (8) @(posedge aclk);
        host.rd(a_cntl, d1, r);
        chk("count moving", {31'h0, exp}, {31'h0, d0 !== d1});
    endtask
    // a missing pulse can only be judged over a window
    task automatic wait_irq(input int lim, input logic exp);
        int n0;
        n0 = irq_cnt;
        for (int i = 0; i < lim && irq_cnt == n0; i++) @(posedge aclk);
        chk("irq pulse", {31'h0, exp}, {31'h0, irq_cnt != n0});
    endtask
    task automatic setup(input logic [15:0] period_lower, input logic [15:0] div);
        w(a_prdl, {16'h0, period_lower});
        w(a_divl, {16'h0, div});
        w(a_ctrl, 32'h0030);
    endtask
    // ========
    // scenarios
    task automatic t_reset();
        rd(a_ctrl, 32'h0);
        rd(a_prdl, 32'hffff);
        moving(1'b1);
        rd(a_rsvd, 32'h0, 2'h2);
        rd(8'h20, 32'h0, 2'h2);
        w(8'h20, 32'h1234, 2'h2);
        rd(a_period_upper, 32'h0);
        w(a_period_upper, 32'hffff5a3c);
        rd(a_period_upper, 32'h5a3c);
    endtask
    task automatic t_ctrl_bits();
        w(a_ctrl, 32'hffff);
        rd(a_ctrl, 32'h4c10);
        rd(a_cntl, 32'hffff);
        rd(a_cntl + 8'h4, 32'h5a3c);
        moving(1'b0);
    endtask
    task automatic t_zero_irq();
        w(a_period_upper, 32'h0);
        setup(16'h3, 16'h1);
        w(a_ctrl, 32'h4000);
        wait_irq(40, 1'b1);
        wait_irq(40, 1'b1);
        chk("irq spacing", 32'd8, irq_gap);
        w(a_ctrl, 32'h4010);
        rd(a_ctrl, 32'hc010);
        w(a_ctrl, 32'h4010);
        rd(a_ctrl, 32'hc010);
        w(a_ctrl, 32'hc010);
        rd(a_ctrl, 32'h4010);
    endtask
    task automatic t_irq_off();
        w(a_ctrl, 32'h8000);
        wait_irq(40, 1'b0);
        w(a_ctrl, 32'h0010);
        rd(a_ctrl, 32'h8010);
    endtask
    task automatic t_emulation();
        setup(16'hffff, 16'h3);
        debug_halt <= 1'b1;
        w(a_ctrl, 32'h0000);
        // the last tick before the hard stop lands a few cycles after the write
        repeat (8) @(posedge aclk);
        moving(1'b0);
        rd(a_cntl, 32'hfffe);
        for (int m = 0; m < 2; m++) begin
            setup(16'hffff, 16'h0);
            w(a_ctrl, (m == 0) ? 32'h0800 : 32'h0c00);
            moving(1'b1);
        end
        // a halt is only left by dropping the breakpoint
        debug_halt <= 1'b0;
        setup(16'd20, 16'h0);
        debug_halt <= 1'b1;
        w(a_ctrl, 32'h4400);
        wait_irq(60, 1'b1);
        rd(a_cntl, 32'h0);
        moving(1'b0);
        debug_halt <= 1'b0;
        moving(1'b1);
    endtask
    task automatic give_verdict();
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // generous bound; the full sequence takes well under a thousand cycles
    initial begin
        repeat (5000) @(posedge aclk);
        mismatches++;
        $display("watchdog expired");
        give_verdict();
    end
    initial begin
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        t_reset();
        t_ctrl_bits();
        t_zero_irq();
        t_irq_off();
        t_emulation();
        give_verdict();
    end
endmodule
`default_nettype wire
